// *** rtl/mmfc_pkg.sv ***
// Package: offsets, field positions, reset values and types of the monitor/switch control bank
`default_nettype none
package mmfc_pkg;
  // Register address width of the internal register port
  localparam int ADDR_W = 8;
  // Register data width
  localparam int DATA_W = 8;
  // Offset of analog_monitor_select
  localparam logic [7:0] ADDR_MON_SEL = 8'h03;
  // Offset of switch_sleep_control
  localparam logic [7:0] ADDR_SW_CTL = 8'h04;
  // analog_monitor_select field positions
  localparam int BIT_USER_FLAG_HIGH = 7;
  localparam int BIT_USER_FLAG_LOW = 6;
  localparam int MON_SEL_LSB = 0;
  localparam int MON_SEL_W = 4;
  // switch_sleep_control field positions
  localparam int BIT_FORCE_SLEEP = 7;
  localparam int BIT_LOAD_MON_EN = 6;
  localparam int BIT_CHG_SW_EN = 1;
  localparam int BIT_DIS_SW_EN = 0;
  // Number of cell voltages the monitor can route
  localparam int NUM_CELLS = 7;
  // Monitor selector codes
  localparam logic [3:0] MON_CODE_OFF = 4'h0;
  localparam logic [3:0] MON_CODE_CELL_LAST = 4'h7;
  localparam logic [3:0] MON_CODE_EXT_TEMP = 4'h8;
  localparam logic [3:0] MON_CODE_INT_TEMP = 4'h9;
  // Reset values
  localparam logic RST_USER_FLAG = 1'b0;
  localparam logic [3:0] RST_MON_SEL = 4'h0;
  localparam logic RST_LOAD_MON_EN = 1'b0;
  localparam logic RST_SW_EN = 1'b0;
  localparam logic [7:0] RST_RDATA = 8'h00;

  // Power state of the device
  typedef enum logic [0:0]
  {
    PWR_ACTIVE = 1'b0,
    PWR_SLEEP = 1'b1
  } mmfc_pwr_e;

  // Whole state of the register bank
  typedef struct packed
  {
    logic user_flag_high;
    logic user_flag_low;
    logic [3:0] monitor_select_field;
    mmfc_pwr_e pwr;
    logic load_monitor_enable;
    logic charge_switch_enable;
    logic discharge_switch_enable;
    logic cell_balance_clear;
    logic [NUM_CELLS-1:0] cell_route;
    logic ext_temp_route;
    logic int_temp_route;
    logic monitor_low_power;
    logic [7:0] rdata;
    logic rvalid;
  } mmfc_state_s;
endpackage : mmfc_pkg
`default_nettype wire

// *** rtl/mmfc_trip_if.sv ***
// Interface: overcurrent events and auto-response qualifiers between bank and trip logic
`default_nettype none
interface mmfc_trip_if;
  // Raw overcurrent and short-circuit events
  logic charge_oc;
  logic discharge_oc;
  logic short_circuit;
  // Auto-response disable bits
  logic charge_oc_auto_disable;
  logic discharge_oc_auto_disable;
  logic short_circuit_auto_disable;
  // Qualified clear requests
  logic trip_charge;
  logic trip_discharge;

  // Bank side: drives events, reads trips
  modport bank
  (
    output charge_oc, discharge_oc, short_circuit,
    output charge_oc_auto_disable, discharge_oc_auto_disable, short_circuit_auto_disable,
    input trip_charge, trip_discharge
  );
  // Trip side: reads events, drives trips
  modport trip
  (
    input charge_oc, discharge_oc, short_circuit,
    input charge_oc_auto_disable, discharge_oc_auto_disable, short_circuit_auto_disable,
    output trip_charge, trip_discharge
  );
endinterface : mmfc_trip_if
`default_nettype wire

// *** rtl/mmfc_trip.sv ***
// Module: qualifies overcurrent events with their auto-response disable bits
`default_nettype none
module mmfc_trip
(
  mmfc_trip_if.trip tif
);
  //////////////////////////////////////////////////////////////////////////////
  // Charge side clears only while auto-response is enabled
  always_comb
  begin
    tif.trip_charge = tif.charge_oc && !tif.charge_oc_auto_disable;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Discharge side: either enabled source turns the switch off
  always_comb
  begin
    tif.trip_discharge = (tif.discharge_oc && !tif.discharge_oc_auto_disable)
      || (tif.short_circuit && !tif.short_circuit_auto_disable);
  end
endmodule : mmfc_trip
`default_nettype wire

// *** rtl/mmfc_regs.sv ***
// Module: analog monitor selector and switch/sleep control register bank
//
// Functional notes
// - Bits 7,6 user flags, retained, no effect
// - Low nibble selects monitor source
// - Reserved bits have no function
// - Bit 7 one forces sleep
// - Sleep clears switches and balance, not selector
// - Sleep bit clears itself on wake
// - Bit 6 controls load monitor circuit
// - Bit 1 drives charge switch
// - Charge overcurrent clears charge enable unless disabled
// - Bit 0 drives discharge switch
// - Discharge overcurrent/short clear discharge enable unless disabled
// - Contents kept through sleep
// - Disabled auto-response keeps switches on
`default_nettype none
module mmfc_regs
(
  input wire logic clk_sys,
  input wire logic rst,
  // Internal register port behind the serial interface
  input wire logic [mmfc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [mmfc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [mmfc_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // Protection events from the analog comparators
  input wire logic charge_oc_evt,
  input wire logic discharge_oc_evt,
  input wire logic short_circuit_evt,
  // Auto-response disable bits from the configuration registers
  input wire logic charge_oc_auto_disable,
  input wire logic discharge_oc_auto_disable,
  input wire logic short_circuit_auto_disable,
  // Wake-up event from the wake circuit
  input wire logic wake_evt,
  // User flags
  output logic user_flag_high,
  output logic user_flag_low,
  // Monitor selector and decoded routes
  output logic [3:0] monitor_select_field,
  output logic [mmfc_pkg::NUM_CELLS-1:0] cell_route,
  output logic ext_temp_route,
  output logic int_temp_route,
  output logic monitor_low_power,
  // Switch and sleep controls
  output logic load_monitor_enable,
  output logic charge_switch_enable,
  output logic discharge_switch_enable,
  output logic cell_balance_clear,
  output logic sleep_active,
  output logic regulator_off
);
  import mmfc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Registered state of the whole bank
  mmfc_state_s st_ff;
  // Next state
  mmfc_state_s nxt_st;
  // Trip carrier to the qualifier
  mmfc_trip_if tif ();
  // Decoded write strobes
  logic wr_mon;
  logic wr_sw;
  // Decoded read strobes
  logic rd_mon;
  logic rd_sw;
  // Monitor code to be decoded
  logic [3:0] dec_code;
  // Per-cell route decode
  logic [NUM_CELLS-1:0] dec_cell;

  //////////////////////////////////////////////////////////////////////////////
  // Trip qualifier

  // Events are levels sampled every cycle; the disable bits gate them
  // Feed events and disable bits into the carrier
  always_comb
  begin
    tif.charge_oc = charge_oc_evt;
    tif.discharge_oc = discharge_oc_evt;
    tif.short_circuit = short_circuit_evt;
    tif.charge_oc_auto_disable = charge_oc_auto_disable;
    tif.discharge_oc_auto_disable = discharge_oc_auto_disable;
    tif.short_circuit_auto_disable = short_circuit_auto_disable;
  end

  // Event qualifier instance
  mmfc_trip u_trip
  (
    .tif(tif.trip)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Address decode

  // Write and read strobes per register
  // Unmapped addresses raise no strobe, so writes there are dropped
  always_comb
  begin
    wr_mon = reg_wr && (reg_addr == ADDR_MON_SEL);
    wr_sw = reg_wr && (reg_addr == ADDR_SW_CTL);
    rd_mon = reg_rd && (reg_addr == ADDR_MON_SEL);
    rd_sw = reg_rd && (reg_addr == ADDR_SW_CTL);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Monitor route decode

  // Decoding the incoming code keeps the routes in step with the selector flop
  // Selector value after this cycle's write
  always_comb
  begin
    if (wr_mon)
    begin
      // Freshly written code
      dec_code = reg_wdata[MON_SEL_LSB +: MON_SEL_W];
    end
    else
    begin
      // Held code
      dec_code = st_ff.monitor_select_field;
    end
  end

  // One route per cell, code n selects cell n
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CELLS; gi++)
    begin : g_cell
      always_comb
      begin
        dec_cell[gi] = (dec_code == 4'(gi + 1));
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  // Priority, lowest first: held state, software write, overcurrent clear,
  // then the power state machine, which holds the switches off while asleep.
  // Reads sample the registered bits, so a read sharing a cycle with a write
  // returns the old value.

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.cell_balance_clear = 1'b0;
    nxt_st.rvalid = 1'b0;

    // Analog monitor select write; bits 5:4 are dropped
    if (wr_mon)
    begin
      nxt_st.user_flag_high = reg_wdata[BIT_USER_FLAG_HIGH];
      nxt_st.user_flag_low = reg_wdata[BIT_USER_FLAG_LOW];
      nxt_st.monitor_select_field = reg_wdata[MON_SEL_LSB +: MON_SEL_W];
    end

    // Switch/sleep control write; bits 5:2 are dropped
    if (wr_sw)
    begin
      nxt_st.load_monitor_enable = reg_wdata[BIT_LOAD_MON_EN];
      nxt_st.charge_switch_enable = reg_wdata[BIT_CHG_SW_EN];
      nxt_st.discharge_switch_enable = reg_wdata[BIT_DIS_SW_EN];
      if (reg_wdata[BIT_FORCE_SLEEP])
      begin
        // Enter sleep; selector and flags stay as they are
        nxt_st.pwr = PWR_SLEEP;
      end
    end

    // Overcurrent auto-response beats a write in the same cycle
    // An event held high keeps the enable low however often it is rewritten
    if (tif.trip_charge)
    begin
      nxt_st.charge_switch_enable = 1'b0;
    end
    if (tif.trip_discharge)
    begin
      nxt_st.discharge_switch_enable = 1'b0;
    end

    // Power state machine
    case (st_ff.pwr)
      PWR_ACTIVE:
      begin
        if (nxt_st.pwr == PWR_SLEEP)
        begin
          // Entry: switches off, balance cleared, selector untouched
          nxt_st.charge_switch_enable = 1'b0;
          nxt_st.discharge_switch_enable = 1'b0;
          nxt_st.cell_balance_clear = 1'b1;
        end
      end
      PWR_SLEEP:
      begin
        // Switches stay off throughout sleep
        nxt_st.charge_switch_enable = 1'b0;
        nxt_st.discharge_switch_enable = 1'b0;
        if (wake_evt)
        begin
          // Sleep bit returns to zero on wake
          nxt_st.pwr = PWR_ACTIVE;
        end
        else
        begin
          nxt_st.pwr = PWR_SLEEP;
        end
      end
      default:
      begin
        nxt_st.pwr = PWR_ACTIVE;
      end
    endcase

    // Monitor routes follow the selector; unlisted codes give nothing
    // Codes ten to fifteen match no route and do not ask for low power
    nxt_st.cell_route = dec_cell;
    nxt_st.ext_temp_route = (dec_code == MON_CODE_EXT_TEMP);
    nxt_st.int_temp_route = (dec_code == MON_CODE_INT_TEMP);
    nxt_st.monitor_low_power = (dec_code == MON_CODE_OFF);

    // Read data shows the live bits, reserved bits zero
    if (rd_mon)
    begin
      nxt_st.rdata = {st_ff.user_flag_high, st_ff.user_flag_low, 2'b00,
                      st_ff.monitor_select_field};
      nxt_st.rvalid = 1'b1;
    end
    else if (rd_sw)
    begin
      nxt_st.rdata = {(st_ff.pwr == PWR_SLEEP), st_ff.load_monitor_enable, 4'h0,
                      st_ff.charge_switch_enable, st_ff.discharge_switch_enable};
      nxt_st.rvalid = 1'b1;
    end
    else if (reg_rd)
    begin
      // Unmapped address reads zero
      nxt_st.rdata = RST_RDATA;
      nxt_st.rvalid = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register; reset is power-on only, sleep never resets it

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_ff.user_flag_high <= RST_USER_FLAG;
      st_ff.user_flag_low <= RST_USER_FLAG;
      st_ff.monitor_select_field <= RST_MON_SEL;
      st_ff.pwr <= PWR_ACTIVE;
      st_ff.load_monitor_enable <= RST_LOAD_MON_EN;
      st_ff.charge_switch_enable <= RST_SW_EN;
      st_ff.discharge_switch_enable <= RST_SW_EN;
      st_ff.cell_balance_clear <= 1'b0;
      st_ff.cell_route <= '0;
      st_ff.ext_temp_route <= 1'b0;
      st_ff.int_temp_route <= 1'b0;
      st_ff.monitor_low_power <= (RST_MON_SEL == MON_CODE_OFF);
      st_ff.rdata <= RST_RDATA;
      st_ff.rvalid <= 1'b0;
    end
    else
    begin
      // Retained through sleep
      // Sleep is a power mode, not a reset, so the bank keeps its contents
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  always_comb
  begin
    reg_rdata = st_ff.rdata;
    reg_rvalid = st_ff.rvalid;
    user_flag_high = st_ff.user_flag_high;
    user_flag_low = st_ff.user_flag_low;
    monitor_select_field = st_ff.monitor_select_field;
    cell_route = st_ff.cell_route;
    ext_temp_route = st_ff.ext_temp_route;
    int_temp_route = st_ff.int_temp_route;
    monitor_low_power = st_ff.monitor_low_power;
    load_monitor_enable = st_ff.load_monitor_enable;
    charge_switch_enable = st_ff.charge_switch_enable;
    discharge_switch_enable = st_ff.discharge_switch_enable;
    cell_balance_clear = st_ff.cell_balance_clear;
    // Regulator and sleep flag share the one power-state flop
    sleep_active = (st_ff.pwr == PWR_SLEEP);
    regulator_off = (st_ff.pwr == PWR_SLEEP);
  end
endmodule : mmfc_regs
`default_nettype wire

// *** sim/mmfc_regs_asserts.sv ***
// Checker: port-level properties of the monitor/switch control bank
`default_nettype none
module mmfc_regs_asserts
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_rvalid,
  input wire logic charge_oc_evt,
  input wire logic discharge_oc_evt,
  input wire logic short_circuit_evt,
  input wire logic charge_oc_auto_disable,
  input wire logic discharge_oc_auto_disable,
  input wire logic wake_evt,
  input wire logic [3:0] monitor_select_field,
  input wire logic ext_temp_route,
  input wire logic int_temp_route,
  input wire logic monitor_low_power,
  input wire logic load_monitor_enable,
  input wire logic charge_switch_enable,
  input wire logic discharge_switch_enable,
  input wire logic cell_balance_clear,
  input wire logic sleep_active,
  input wire logic regulator_off
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Write of the sleep bit while awake
  sequence sleep_req;
    reg_wr && reg_addr == 8'h04 && reg_wdata[7] && !sleep_active;
  endsequence
  // Sleep flag, balance clear and both switches off after sleep entry
  sequence sleep_state;
    sleep_active && cell_balance_clear && !charge_switch_enable && !discharge_switch_enable;
  endsequence
  sleep_entry_a: assert property (sleep_req |=> sleep_state)
    else $error("sleep entry wrong");
  sel_kept_a: assert property (sleep_req |=> $stable(monitor_select_field))
    else $error("selector changed on sleep");
  reg_off_a: assert property ((reg_wr && reg_addr == 8'h04 && reg_wdata[7] && !sleep_active)
    || (regulator_off && !wake_evt) |=> regulator_off)
    else $error("regulator not held off in sleep");
  wake_clear_a: assert property (sleep_active && wake_evt && !reg_wr |=> !sleep_active)
    else $error("sleep not left on wake");
  chg_trip_a: assert property (charge_oc_evt && !charge_oc_auto_disable |=> !charge_switch_enable)
    else $error("charge enable not cleared");
  dis_keep_a: assert property (discharge_oc_evt && discharge_oc_auto_disable && !short_circuit_evt
    && discharge_switch_enable && !reg_wr |=> discharge_switch_enable)
    else $error("discharge enable cleared while disabled");
  sel_decode_a: assert property (ext_temp_route == (monitor_select_field == 4'h8)
    && int_temp_route == (monitor_select_field == 4'h9)
    && monitor_low_power == (monitor_select_field == 4'h0))
    else $error("selector decode wrong");
  rvalid_pulse_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read answer missing");
  rvalid_idle_a: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read answer without read");
  ldmon_write_a: assert property (reg_wr && reg_addr == 8'h04
    |=> load_monitor_enable == $past(reg_wdata[6]))
    else $error("load monitor enable wrong");
endmodule : mmfc_regs_asserts
`default_nettype wire

// *** sim/mmfc_host.sv ***
// Partner: microcontroller side of the internal register port
`default_nettype none
module mmfc_host
(
  input wire logic clk_sys,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One-cycle write strobe, effect settled on return
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    #1;
  endtask : wr
  // One-cycle read strobe, answer taken one cycle after the read edge
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
  endtask : rd
endmodule : mmfc_host
`default_nettype wire

// *** sim/tb.sv ***
// Testbench: self-checking scenarios for the control register bank
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mmfc_pkg::*;
  logic clk_sys, rst, reg_wr, reg_rd, reg_rvalid, charge_oc_evt, discharge_oc_evt;
  logic short_circuit_evt, charge_oc_auto_disable, discharge_oc_auto_disable, wake_evt;
  logic short_circuit_auto_disable, user_flag_high, user_flag_low, ext_temp_route;
  logic int_temp_route, monitor_low_power, load_monitor_enable, charge_switch_enable;
  logic discharge_switch_enable, cell_balance_clear, sleep_active, regulator_off;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] monitor_select_field;
  logic [6:0] cell_route;
  int num_errors = 0;
  int checks = 0;
  mmfc_regs dut (.*);
  mmfc_host host (.*);
  // Clock from time zero, toggling every 5 ns
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Compare and count
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    checks++;
    if (e !== g)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Read one register and judge data and answer strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a);
    chk("reg_rvalid", 10'h1, {9'h0, reg_rvalid});
    chk("reg_rdata", {2'h0, e}, {2'h0, reg_rdata});
  endtask : rd_chk
  // Every selector code with flags set and reserved bits written
  task automatic t_sel;
    logic [9:0] e;
    for (int c = 0; c < 16; c++)
    begin
      host.wr(ADDR_MON_SEL, {4'hf, 4'(c)});
      rd_chk(ADDR_MON_SEL, {4'hc, 4'(c)});
      e = {((c >= 1 && c <= 7) ? 7'(1 << (c - 1)) : 7'h0), c == 8, c == 9, c == 0};
      chk("routes", e, {cell_route, ext_temp_route, int_temp_route, monitor_low_power});
    end
  endtask : t_sel
  // Switch bits, reserved bits, unmapped address
  task automatic t_sw;
    host.wr(ADDR_SW_CTL, 8'h7f);
    rd_chk(ADDR_SW_CTL, 8'h43);
    chk("sw", 10'h7, {7'h0, load_monitor_enable, charge_switch_enable,
      discharge_switch_enable});
    host.wr(ADDR_SW_CTL, 8'h00);
    chk("sw_off", 10'h0, {7'h0, load_monitor_enable, charge_switch_enable,
      discharge_switch_enable});
    host.wr(8'h07, 8'hff);
    rd_chk(8'h07, 8'h00);
  endtask : t_sw
  // Each event with auto-response on and off
  task automatic t_trip;
    for (int i = 0; i < 6; i++)
    begin
      host.wr(ADDR_SW_CTL, 8'h03);
      @(posedge clk_sys);
      {charge_oc_auto_disable, discharge_oc_auto_disable, short_circuit_auto_disable} <= {3{i > 2}};
      {charge_oc_evt, discharge_oc_evt, short_circuit_evt} <= 3'(3'h4 >> (i % 3));
      @(posedge clk_sys);
      {charge_oc_evt, discharge_oc_evt, short_circuit_evt} <= 3'h0;
      #1;
      chk("trip", {8'h0, !(i == 0), !(i == 1 || i == 2)},
        {8'h0, charge_switch_enable, discharge_switch_enable});
      rd_chk(ADDR_SW_CTL, {6'h0, !(i == 0), !(i == 1 || i == 2)});
    end
    // Overcurrent clear beats a same-cycle write of one
    @(posedge clk_sys);
    {charge_oc_auto_disable, discharge_oc_auto_disable, short_circuit_auto_disable} <= 3'h0;
    charge_oc_evt <= 1'b1;
    host.wr(ADDR_SW_CTL, 8'h03);
    @(posedge clk_sys);
    charge_oc_evt <= 1'b0;
    #1;
    chk("race", 10'h1, {8'h0, charge_switch_enable, discharge_switch_enable});
  endtask : t_trip
  // Sleep entry, retention, refused switch write, wake
  task automatic t_sleep;
    host.wr(ADDR_MON_SEL, 8'hc5);
    host.wr(ADDR_SW_CTL, 8'h43);
    host.wr(ADDR_SW_CTL, 8'h83);
    chk("entry", 10'h1c, {5'h0, sleep_active, regulator_off, cell_balance_clear,
      charge_switch_enable, discharge_switch_enable});
    host.wr(ADDR_SW_CTL, 8'h03);
    rd_chk(ADDR_SW_CTL, 8'h80);
    rd_chk(ADDR_MON_SEL, 8'hc5);
    chk("held", 10'h0c5, {2'h0, user_flag_high, user_flag_low, 2'h0,
      monitor_select_field});
    @(posedge clk_sys);
    wake_evt <= 1'b1;
    @(posedge clk_sys);
    wake_evt <= 1'b0;
    #1;
    chk("wake", 10'h0, {8'h0, sleep_active, regulator_off});
    rd_chk(ADDR_SW_CTL, 8'h00);
  endtask : t_sleep
  // Verdict and end of run
  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // Main sequence
  initial
  begin
    {rst, charge_oc_evt, discharge_oc_evt, short_circuit_evt, wake_evt} = 5'h10;
    {charge_oc_auto_disable, discharge_oc_auto_disable, short_circuit_auto_disable} = 3'h0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk("reset", 10'h201, {monitor_low_power, sleep_active, charge_switch_enable,
      discharge_switch_enable, load_monitor_enable, 5'h1});
    rd_chk(ADDR_SW_CTL, RST_RDATA);
    t_sel();
    t_sw();
    t_trip();
    t_sleep();
    final_report();
  end
  // Watchdog well beyond the roughly 140 cycles of the tests
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    final_report();
  end
endmodule : tb
bind mmfc_regs mmfc_regs_asserts u_asserts (.*);
`default_nettype wire
